// >>> hw/acpp_pkg.sv
// Shared constants for the converter control pins, serial port and host.
// Assumes a 200 MHz system clock on the host side.
package acpp_pkg;
   // ----------------------------------------
   // Serial command framing
   // ----------------------------------------
   localparam int         BYTE_W        = 8;
   localparam int         ADDR_W        = 6;
   localparam int         COMM_ZERO_POS = 7;
   localparam int         COMM_READ_POS = 6;
   localparam logic [5:0] PORT_ADDR     = 6'h01;
   // ----------------------------------------
   // Port register fields
   // ----------------------------------------
   localparam int         PIN0_VAL_POS   = 7;
   localparam int         PIN1_VAL_POS   = 6;
   localparam int         PIN0_DIR_POS   = 5;
   localparam int         PIN1_DIR_POS   = 4;
   localparam int         READY_MODE_POS = 3;
   localparam int         ALIGN_EN_POS   = 0;
   localparam logic [7:0] PORT_RESET     = 8'h30;
   localparam logic [7:0] PORT_WMASK     = 8'hF9;
   // ----------------------------------------
   // Host register map (byte offsets)
   // ----------------------------------------
   localparam logic [3:0] HOST_CTRL_OFS  = 4'h0;
   localparam logic [3:0] HOST_CMD_OFS   = 4'h4;
   localparam logic [3:0] HOST_STAT_OFS  = 4'h8;
   localparam int         CTRL_FRAME_POS = 0;
   localparam int         CTRL_RESET_POS = 1;
   localparam logic [1:0] CTRL_RESET_VAL = 2'h3;
   localparam int         STAT_BUSY_POS  = 0;
   localparam int         STAT_RX_LSB    = 8;
   localparam int         CMD_DATA_LSB   = 8;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_PS = 5000;
   localparam int SCLK_HALF_PS  = 20000;
   localparam int SCLK_HALF_CYC = (SCLK_HALF_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage

// >>> hw/acpp_link_if.sv
// Serial link and reset pin between host and converter.
// Resolves the pulled-up select line and the shared data-out line.
`timescale 1ns/1ps
interface acpp_link_if;
   logic sclk;
   logic cs_n_out;
   logic cs_n_oe_n;
   logic cs_n;
   logic din;
   logic dout_out;
   logic dout_oe_n;
   logic dout;
   logic reset_n;

   // Pull-ups on undriven lines
   assign cs_n = cs_n_oe_n ? 1'b1 : cs_n_out;
   assign dout = dout_oe_n ? 1'b1 : dout_out;

   modport host   (output sclk, cs_n_out, cs_n_oe_n, din, reset_n, input dout);
   modport device (input sclk, cs_n, din, reset_n, output dout_out, dout_oe_n);
endinterface

// >>> hw/acpp_device.sv
// Converter control pins: serial port, port register, two digital pins.
// Assumes the host makes sclk (idle high, sample on rise) and the reset pin.
`timescale 1ns/1ps
module acpp_device
(
   // Master clock
   input  wire logic clk_i,
   // Serial link
   acpp_link_if.device link,
   // Master clock output control and pin
   input  wire logic mclk_out_en_i,
   output wire logic master_clock_output_o,
   // General-purpose pin zero
   input  wire logic gp_pin_zero_i,
   output wire logic gp_pin_zero_o,
   output wire logic gp_pin_zero_oe_n_o,
   // Pin one, also the align input
   input  wire logic align_or_gp_pin_one_i,
   output wire logic align_or_gp_pin_one_o,
   output wire logic align_or_gp_pin_one_oe_n_o,
   // Modulator and filter alignment
   output wire logic align_hold_o,
   output wire logic align_restart_o
);
   // ----------------------------------------
   // Link domain (serial clock)
   // ----------------------------------------
   logic       frame_clr;
   logic       reg_clr;
   logic [2:0] bit_cnt_reg;
   logic [6:0] shift_reg;
   logic       data_phase_reg;
   logic       read_reg;
   logic [5:0] addr_reg;
   logic [7:0] tx_reg;
   logic [7:0] port_reg;
   logic       dout_reg;
   logic [1:0] lvl_meta_reg;
   logic [1:0] lvl_sync_reg;
   logic       byte_done;
   logic [7:0] new_byte;

   // Readback of one register; pins report their live level
   function automatic logic [7:0] read_value(input logic [5:0] addr, input logic [7:0] port,
                                             input logic [1:0] lvl);
      logic [7:0] v;
      v = 8'h00;
      if (addr == acpp_pkg::PORT_ADDR)
      begin
         v = port & acpp_pkg::PORT_WMASK;
         v[acpp_pkg::PIN0_VAL_POS] = lvl[0];
         v[acpp_pkg::PIN1_VAL_POS] = lvl[1];
      end
      return v;
   endfunction

   // deselect clears frame
   // Async clear: the serial clock stops while deselected
   assign frame_clr = link.cs_n | ~link.reset_n;
   assign reg_clr   = ~link.reset_n;
   assign byte_done = (bit_cnt_reg == 3'h7);
   assign new_byte  = {shift_reg, link.din};

   always_ff @(posedge link.sclk or posedge frame_clr)
   begin
      if (frame_clr)
      begin
         bit_cnt_reg <= 3'h0;
         shift_reg   <= 7'h00;
      end
      else
      begin
         shift_reg   <= new_byte[6:0];
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
      end
   end

   // Command then data byte; a command with top bit set is dropped
   // byte count alone aligns
   // Phase survives deselect so framed bytes still pair up
   always_ff @(posedge link.sclk or posedge reg_clr)
   begin
      if (reg_clr)
      begin
         data_phase_reg <= 1'b0;
         read_reg       <= 1'b0;
         addr_reg       <= 6'h00;
         tx_reg         <= 8'h00;
      end
      else if (byte_done)
      begin
         if (!data_phase_reg && !new_byte[acpp_pkg::COMM_ZERO_POS])
         begin
            data_phase_reg <= 1'b1;
            read_reg       <= new_byte[acpp_pkg::COMM_READ_POS];
            addr_reg       <= new_byte[acpp_pkg::ADDR_W-1:0];
            tx_reg         <= read_value(new_byte[acpp_pkg::ADDR_W-1:0], port_reg, lvl_sync_reg);
         end
         else
         begin
            data_phase_reg <= 1'b0;
         end
      end
   end

   // register written
   // Reserved bits stay zero
   always_ff @(posedge link.sclk or posedge reg_clr)
   begin
      if (reg_clr)
      begin
         port_reg <= acpp_pkg::PORT_RESET;
      end
      else if (byte_done && data_phase_reg && !read_reg && addr_reg == acpp_pkg::PORT_ADDR)
      begin
         port_reg <= new_byte & acpp_pkg::PORT_WMASK;
      end
   end

   always_ff @(posedge link.sclk or posedge reg_clr)
   begin
      if (reg_clr)
      begin
         lvl_meta_reg <= 2'h0;
         lvl_sync_reg <= 2'h0;
      end
      else
      begin
         lvl_meta_reg <= {align_or_gp_pin_one_i, gp_pin_zero_i};
         lvl_sync_reg <= lvl_meta_reg;
      end
   end

   // Output bit changes on the falling edge, MSB first
   always_ff @(negedge link.sclk or posedge frame_clr)
   begin
      if (frame_clr)
      begin
         dout_reg <= 1'b1;
      end
      else
      begin
         dout_reg <= tx_reg[~bit_cnt_reg];
      end
   end

   assign link.dout_out  = dout_reg;
   assign link.dout_oe_n = link.cs_n;

   // ----------------------------------------
   // Master clock domain
   // ----------------------------------------
   logic       rst_meta_reg;
   logic       rst_sync_reg;
   logic [4:0] cfg_meta_reg;
   logic [4:0] cfg_sync_reg;
   logic       en_meta_reg;
   logic       en_sync_reg;
   logic       p1_meta_reg;
   logic       p1_sync_reg;
   logic       p1_last_reg;
   logic       pin0_reg;
   logic       pin0_oe_n_reg;
   logic       pin1_reg;
   logic       pin1_oe_n_reg;
   logic       hold_reg;
   logic       restart_reg;
   logic       dir0;
   logic       dir1;
   logic       align_en;

   // Reset pin into master clock domain
   always_ff @(posedge clk_i)
   begin
      rst_meta_reg <= ~link.reset_n;
      rst_sync_reg <= rst_meta_reg;
   end

   // config bits synced
   // Bits are quasi-static, so each crosses on its own
   always_ff @(posedge clk_i)
   begin
      cfg_meta_reg <= {port_reg[acpp_pkg::PIN0_VAL_POS], port_reg[acpp_pkg::PIN1_VAL_POS],
                       port_reg[acpp_pkg::PIN0_DIR_POS], port_reg[acpp_pkg::PIN1_DIR_POS],
                       port_reg[acpp_pkg::ALIGN_EN_POS]};
      cfg_sync_reg <= cfg_meta_reg;
      p1_meta_reg  <= align_or_gp_pin_one_i;
      p1_sync_reg  <= p1_meta_reg;
      en_meta_reg  <= mclk_out_en_i;
      en_sync_reg  <= en_meta_reg;
   end

   assign dir0     = cfg_sync_reg[2];
   assign dir1     = cfg_sync_reg[1];
   assign align_en = cfg_sync_reg[0];

   // pin zero and pin one drive
   // Direction bit 1 means input; align mode forces pin one to input
   always_ff @(posedge clk_i)
   begin
      if (rst_sync_reg)
      begin
         pin0_reg      <= 1'b0;
         pin0_oe_n_reg <= 1'b1;
         pin1_reg      <= 1'b0;
         pin1_oe_n_reg <= 1'b1;
      end
      else
      begin
         pin0_reg      <= cfg_sync_reg[4];
         pin0_oe_n_reg <= dir0;
         pin1_reg      <= cfg_sync_reg[3];
         pin1_oe_n_reg <= dir1 | align_en;
      end
   end

   // align from pin one
   // Low holds filter, rising edge restarts it
   always_ff @(posedge clk_i)
   begin
      if (rst_sync_reg)
      begin
         p1_last_reg <= 1'b1;
         hold_reg    <= 1'b0;
         restart_reg <= 1'b0;
      end
      else
      begin
         p1_last_reg <= p1_sync_reg;
         hold_reg    <= align_en & ~p1_sync_reg;
         restart_reg <= align_en & p1_sync_reg & ~p1_last_reg;
      end
   end

   assign gp_pin_zero_o              = pin0_reg;
   assign gp_pin_zero_oe_n_o         = pin0_oe_n_reg;
   assign align_or_gp_pin_one_o      = pin1_reg;
   assign align_or_gp_pin_one_oe_n_o = pin1_oe_n_reg;
   assign align_hold_o               = hold_reg;
   assign align_restart_o            = restart_reg;

   // clock output
   // Never reset; an external master clock is assumed
   assign master_clock_output_o = en_sync_reg & ~clk_i;
endmodule // acpp_device

// >>> hw/acpp_host.sv
// Host end: Wishbone slave that runs two-byte serial transfers.
// Assumes the device samples on the rising sclk edge and drives on falling.
`timescale 1ns/1ps
module acpp_host
#(
   parameter int SCLK_HALF = acpp_pkg::SCLK_HALF_CYC
)
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [3:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output wire logic [31:0] dat_o,
   output wire logic        ack_o,
   // Serial link
   acpp_link_if.host        link
);
   typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH, ST_GAP} acpp_state_t;

   acpp_state_t state_reg;
   logic [7:0]  cnt_reg;
   logic [3:0]  bit_idx_reg;
   logic [15:0] tx_reg;
   logic [7:0]  rx_reg;
   logic        sclk_reg;
   logic        cs_reg;
   logic        frame_reg;
   logic        dev_rst_reg;
   logic        ack_reg;
   logic [31:0] dat_reg;
   logic        miso_meta_reg;
   logic        miso_sync_reg;
   logic        acc;
   logic        start;
   logic        half_done;

   assign acc       = cyc_i & stb_i & ~ack_reg;
   assign start     = acc & we_i & sel_i[0] & (adr_i == acpp_pkg::HOST_CMD_OFS) & (state_reg == ST_IDLE);
   assign half_done = (cnt_reg == 8'(SCLK_HALF - 1));

   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   // One-cycle answer to any address; unmapped reads zero
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_reg     <= 1'b0;
         dat_reg     <= 32'h00000000;
         frame_reg   <= acpp_pkg::CTRL_RESET_VAL[acpp_pkg::CTRL_FRAME_POS];
         dev_rst_reg <= acpp_pkg::CTRL_RESET_VAL[acpp_pkg::CTRL_RESET_POS];
      end
      else
      begin
         ack_reg <= acc;
         dat_reg <= 32'h00000000;
         if (acc && we_i && sel_i[0] && adr_i == acpp_pkg::HOST_CTRL_OFS)
         begin
            frame_reg   <= dat_i[acpp_pkg::CTRL_FRAME_POS];
            dev_rst_reg <= dat_i[acpp_pkg::CTRL_RESET_POS];
         end
         if (acc && !we_i && adr_i == acpp_pkg::HOST_CTRL_OFS)
         begin
            dat_reg[acpp_pkg::CTRL_FRAME_POS] <= frame_reg;
            dat_reg[acpp_pkg::CTRL_RESET_POS] <= dev_rst_reg;
         end
         if (acc && !we_i && adr_i == acpp_pkg::HOST_STAT_OFS)
         begin
            dat_reg[acpp_pkg::STAT_BUSY_POS]                       <= (state_reg != ST_IDLE);
            dat_reg[acpp_pkg::STAT_RX_LSB +: acpp_pkg::BYTE_W]     <= rx_reg;
         end
      end
   end

   // Returned data bit, from the other party's timing
   always_ff @(posedge clk_i)
   begin
      miso_meta_reg <= link.dout;
      miso_sync_reg <= miso_meta_reg;
   end

   // ----------------------------------------
   // Serial engine
   // ----------------------------------------
   // host makes the clock
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_reg   <= ST_IDLE;
         cnt_reg     <= 8'h00;
         bit_idx_reg <= 4'h0;
         tx_reg      <= 16'h0000;
         rx_reg      <= 8'h00;
         sclk_reg    <= 1'b1;
         cs_reg      <= 1'b1;
      end
      else
      begin
         cnt_reg <= half_done ? 8'h00 : cnt_reg + 8'h01;
         unique case (state_reg)
            ST_IDLE:
            begin
               cnt_reg <= 8'h00;
               if (start)
               begin
                  tx_reg    <= {dat_i[7:0], dat_i[acpp_pkg::CMD_DATA_LSB +: acpp_pkg::BYTE_W]};
                  cs_reg    <= 1'b0;
                  state_reg <= ST_SETUP;
               end
            end
            ST_SETUP:
            begin
               if (half_done)
               begin
                  sclk_reg  <= 1'b0;
                  state_reg <= ST_LOW;
               end
            end
            ST_LOW:
            begin
               // Sampling needs SCLK_HALF of at least 3
               if (half_done)
               begin
                  sclk_reg  <= 1'b1;
                  rx_reg    <= {rx_reg[6:0], miso_sync_reg};
                  state_reg <= ST_HIGH;
               end
            end
            ST_HIGH:
            begin
               if (half_done)
               begin
                  bit_idx_reg <= bit_idx_reg + 4'h1;
                  tx_reg      <= {tx_reg[14:0], 1'b0};
                  if (bit_idx_reg == 4'hF || (bit_idx_reg == 4'h7 && frame_reg))
                  begin
                     cs_reg    <= 1'b1;
                     state_reg <= ST_GAP;
                  end
                  else
                  begin
                     sclk_reg  <= 1'b0;
                     state_reg <= ST_LOW;
                  end
               end
            end
            ST_GAP:
            begin
               if (half_done)
               begin
                  cs_reg    <= (bit_idx_reg == 4'h0);
                  state_reg <= (bit_idx_reg == 4'h0) ? ST_IDLE : ST_SETUP;
               end
            end
         endcase
      end
   end

   assign link.cs_n_out  = frame_reg ? cs_reg : 1'b0;
   assign link.cs_n_oe_n = 1'b0;
   assign link.sclk      = sclk_reg;
   assign link.din       = tx_reg[15];
   assign link.reset_n   = ~dev_rst_reg;
   assign dat_o          = dat_reg;
   assign ack_o          = ack_reg;
endmodule // acpp_host

// >>> test/acpp_link_assertions.sv
// Checker for the serial link joining the host and converter ends.
// Assumes the host clock and its synchronous reset; link nets as plain inputs.
`timescale 1ns/1ps
module acpp_link_assertions
#(
   parameter int SCLK_HALF = 4
)
(
   // Host clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Link nets
   input  wire logic sclk,
   input  wire logic cs_n_out,
   input  wire logic cs_n_oe_n,
   input  wire logic cs_n,
   input  wire logic din,
   input  wire logic dout_out,
   input  wire logic dout_oe_n,
   input  wire logic dout,
   input  wire logic reset_n
);
   // ------
   // Helpers
   // ------
   logic [7:0] low_cnt_reg;
   logic [7:0] bit_cnt_reg;
   logic       sclk_q_reg;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Length of the running sclk low phase
   always_ff @(posedge clk_i)
   begin
      if (rst_i || sclk)
         low_cnt_reg <= 8'h00;
      else
         low_cnt_reg <= low_cnt_reg + 8'h01;
   end

   // Rising sclk edges seen inside one select frame; cleared while deselected
   always_ff @(posedge clk_i)
   begin
      sclk_q_reg <= sclk;
      if (rst_i || cs_n)
         bit_cnt_reg <= 8'h00;
      else if (sclk && !sclk_q_reg)
         bit_cnt_reg <= bit_cnt_reg + 8'h01;
   end

   // Two high samples in a row inside a frame
   sequence s_high_pair;
      sclk && !cs_n ##1 sclk && !cs_n;
   endsequence

   // Link relations
   chk_cs_pull_high:
      assert property (cs_n_oe_n |-> cs_n) else $error("select not high while undriven");
   chk_dout_released:
      assert property (cs_n |-> dout_oe_n && dout) else $error("data out driven while deselected");
   chk_dout_driven:
      assert property (!cs_n |-> !dout_oe_n) else $error("data out not driven while selected");
   chk_sclk_idle:
      assert property (cs_n |-> sclk) else $error("serial clock moves outside a frame");
   chk_low_half:
      assert property ($rose(sclk) |-> low_cnt_reg == 8'(SCLK_HALF)) else $error("serial clock low phase wrong");
   chk_frame_bits:
      assert property ($rose(cs_n) |-> bit_cnt_reg == 8'h08) else $error("frame is not eight bits");
   chk_dout_on_fall:
      assert property (!cs_n && $past(!cs_n) && reset_n && $past(reset_n) && $changed(dout_out) |-> $fell(sclk))
         else $error("data out moved off a falling clock");
   chk_din_steady:
      assert property (s_high_pair |-> $stable(din)) else $error("data in moved while clock high");
endmodule // acpp_link_assertions

// >>> test/adc_control_pins_and_port_bench.sv
// Bench joining host and converter ends; drives Wishbone and the two pins.
// Assumes a 5 ns host clock, 15 ns master clock, SCLK_HALF of 4.
`timescale 1ns/1ps
module adc_control_pins_and_port_bench;
   // ------
   // Signals
   // ------
   logic        clk_i = 1'b0;
   logic        mclk = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, chk = 1'b0;
   logic [3:0]  adr = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] dat_o, rd_data;
   logic        ack_o;
   logic        p0_drv = 1'b0, p1_drv = 1'b1, mclk_en = 1'b1, e0, e1;
   logic [7:0]  v;
   logic [31:0] exp_q[$];
   int          seed = 62;
   int          err_total = 0;
   int          comparisons = 0;
   int          pulses = 0;
   wire         p0_o, p0_oe_n, p1_o, p1_oe_n, mco, hold, restart;
   // Pins resolve to bench level while the device releases them
   // board keeps released pins at a defined level
   wire         p0_pin = p0_oe_n ? p0_drv : p0_o;
   wire         p1_pin = p1_oe_n ? p1_drv : p1_o;

   acpp_link_if link ();
   acpp_host #(.SCLK_HALF(4)) i_acpp_host (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .link(link.host));
   acpp_device i_acpp_device (.clk_i(mclk), .link(link.device), .mclk_out_en_i(mclk_en),
      .master_clock_output_o(mco), .gp_pin_zero_i(p0_pin), .gp_pin_zero_o(p0_o), .gp_pin_zero_oe_n_o(p0_oe_n),
      .align_or_gp_pin_one_i(p1_pin), .align_or_gp_pin_one_o(p1_o), .align_or_gp_pin_one_oe_n_o(p1_oe_n),
      .align_hold_o(hold), .align_restart_o(restart));
   acpp_link_assertions #(.SCLK_HALF(4)) i_acpp_link_assertions (.clk_i(clk_i), .rst_i(rst_i),
      .sclk(link.sclk), .cs_n_out(link.cs_n_out), .cs_n_oe_n(link.cs_n_oe_n), .cs_n(link.cs_n), .din(link.din),
      .dout_out(link.dout_out), .dout_oe_n(link.dout_oe_n), .dout(link.dout), .reset_n(link.reset_n));

   // Clocks; master clock offset so edges never coincide
   always #2.5 clk_i = ~clk_i;
   initial
   begin
      #1.1;
      forever #7.5 mclk = ~mclk;
   end

   // Count alignment restarts
   always @(posedge mclk)
   begin
      if (restart === 1'b1)
         pulses++;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] expv);
      comparisons++;
      if (seen !== expv)
      begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, expv);
      end
   endtask

   task automatic stop_test();
      if (err_total == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Classic single Wishbone cycle; held until ack is sampled
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic c, input logic [31:0] e);
      int n;
      if (c)
         exp_q.push_back(e);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      chk <= c;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack_o !== 1'b1 && n < 200);
      rd_data = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 200)
      begin
         err_total++;
         stop_test();
      end
   endtask

   // Serial transfer, then poll busy with a bound
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] d);
      int n;
      wb(1'b1, 4'h4, {16'h0000, d, cmd}, 1'b0, 32'h0);
      n = 0;
      rd_data = 32'h1;
      while (rd_data[0] !== 1'b0 && n < 200)
      begin
         wb(1'b0, 4'h8, 32'h0, 1'b0, 32'h0);
         n++;
      end
      if (n >= 200)
      begin
         err_total++;
         stop_test();
      end
   endtask

   // Read the port register; received byte checked through the queue
   task automatic rd_port(input logic [7:0] e);
      xfer(8'h41, 8'h00);
      wb(1'b0, 4'h8, 32'h0, 1'b1, {16'h0000, e, 8'h00});
   endtask

   // Pin updates land a few master clocks after the transfer
   task automatic settle();
      repeat (10) @(posedge mclk);
      @(posedge clk_i);
   endtask

   // Read results compared against oldest note
   always @(posedge clk_i)
   begin
      if (ack_o === 1'b1 && !we && chk)
         check(dat_o, exp_q.pop_front());
   end

   // ------
   // Scenarios
   // ------
   initial
   begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b1, 4'h0, 32'h1, 1'b0, 32'h0);
      wb(1'b0, 4'hC, 32'h0, 1'b1, 32'h0);
      // Defaults: both pins inputs reading board levels
      v = 8'($random(seed));
      p0_drv <= v[0];
      p1_drv <= v[1];
      settle();
      rd_port({v[0], v[1], 6'h30});
      check({p0_oe_n, p1_oe_n}, 2'b11);
      // Random directions, values and board levels
      repeat (6)
      begin
         v = 8'($random(seed));
         p0_drv <= v[3];
         p1_drv <= v[2];
         e0 = v[5] ? v[3] : v[7];
         e1 = v[4] ? v[2] : v[6];
         xfer(8'h01, {v[7:4], 4'h0});
         settle();
         check({p0_oe_n, p1_oe_n, p0_pin, p1_pin}, {v[5:4], e0, e1});
         rd_port({e0, e1, v[5:4], 4'h0});
      end
      // Align mode: pin one low holds, rise restarts once
      p1_drv <= 1'b1;
      xfer(8'h01, 8'h31);
      settle();
      p1_drv <= 1'b0;
      settle();
      check({hold, p1_oe_n}, 2'b11);
      pulses = 0;
      p1_drv <= 1'b1;
      settle();
      check({hold, pulses[7:0]}, 9'h001);
      // Device reset: pins released, clock output still runs
      xfer(8'h01, 8'h00);
      wb(1'b1, 4'h0, 32'h3, 1'b0, 32'h0);
      settle();
      check({p0_oe_n, p1_oe_n}, 2'b11);
      @(posedge mclk);
      #1;
      check(mco, 1'b0);
      @(negedge mclk);
      #1;
      check(mco, 1'b1);
      wb(1'b1, 4'h0, 32'h1, 1'b0, 32'h0);
      rd_port({p0_drv, p1_drv, 6'h30});
      // Clock output switched off
      @(posedge clk_i);
      mclk_en <= 1'b0;
      repeat (3) @(negedge mclk);
      #1;
      check(mco, 1'b0);
      @(posedge clk_i);
      mclk_en <= 1'b1;
      // Three-wire mode with select held low
      wb(1'b1, 4'h0, 32'h0, 1'b0, 32'h0);
      xfer(8'h01, 8'hC0);
      settle();
      rd_port(8'hC0);
      check(link.cs_n, 1'b0);
      // Let the watcher take the last read before closing
      @(posedge clk_i);
      check(exp_q.size(), 0);
      stop_test();
   end
endmodule // adc_control_pins_and_port_bench
